// ===== design/bmx_matrix.sv
// bmx_matrix: slave side of a multi-layer interconnect, ten slave ports.
// Assumes masters hold request, address and data until mReady; one clock.
//
// Design decisions made here: the register addresses and the AXI4-Lite interface to the registers.
`timescale 1ns/1ps
`default_nettype none
module bmx_matrix
	import bmx_pkg::*;
(
	input wire logic clk_sys,
	input wire logic rst_n,
	// register bus
	input wire logic [RAW-1:0] s_axi_awaddr,
	input wire logic s_axi_awvalid,
	output logic s_axi_awready,
	input wire logic [DW-1:0] s_axi_wdata,
	input wire logic [STRB_W-1:0] s_axi_wstrb,
	input wire logic s_axi_wvalid,
	output logic s_axi_wready,
	output logic [1:0] s_axi_bresp,
	output logic s_axi_bvalid,
	input wire logic s_axi_bready,
	input wire logic [RAW-1:0] s_axi_araddr,
	input wire logic s_axi_arvalid,
	output logic s_axi_arready,
	output logic [DW-1:0] s_axi_rdata,
	output logic [1:0] s_axi_rresp,
	output logic s_axi_rvalid,
	input wire logic s_axi_rready,
	// master ports
	input wire logic [NM-1:0] mReq,
	input wire logic [AW-1:0] mAddr [NM],
	input wire logic [NM-1:0] mWrite,
	input wire logic [DW-1:0] mWdata [NM],
	input wire logic [NM-1:0] mLast,
	output logic [NM-1:0] mReady,
	output logic [NM-1:0] mErr,
	output logic [DW-1:0] mRdata [NM],
	// slave ports
	output logic [NS-1:0] sSel,
	output logic [AW-1:0] sAddr [NS],
	output logic [NS-1:0] sWrite,
	output logic [DW-1:0] sWdata [NS],
	output logic [NS-1:0] sLast,
	output logic [MIW-1:0] sMaster [NS],
	input wire logic [NS-1:0] sReady,
	input wire logic [DW-1:0] sRdata [NS]
);

	// configuration and bus state
	logic [NM-1:0] remap;
	bmx_kind_t kindCfg [NS];
	logic [MIW-1:0] pinnedCfg [NS];
	logic awHeld;
	logic [RAW-1:0] awAddr;
	logic wHeld;
	logic [DW-1:0] wData;
	logic [STRB_W-1:0] wStrb;
	logic [NM-1:0] next_remap;
	bmx_kind_t next_kindCfg [NS];
	logic [MIW-1:0] next_pinnedCfg [NS];
	logic next_awHeld;
	logic [RAW-1:0] next_awAddr;
	logic next_wHeld;
	logic [DW-1:0] next_wData;
	logic [STRB_W-1:0] next_wStrb;
	logic [1:0] next_bresp;
	logic next_bvalid;
	logic [DW-1:0] next_rdata;
	logic [1:0] next_rresp;
	logic next_rvalid;
	logic [MIW:0] wrSlot;
	logic [MIW:0] rdCfg;
	logic [MIW:0] rdStat;
	logic [DW-1:0] word;

	// routing state
	logic [NM-1:0] mHit;
	logic [MIW-1:0] mTarget [NM];
	logic [NM-1:0] reqVec [NS];
	logic [MIW-1:0] owner [NS];
	logic [NS-1:0] ownerValid;
	logic [NS-1:0] beatDone;
	logic [NS-1:0] beatLast;
	logic [NM-1:0] errPend;
	logic [NM-1:0] next_errPend;

	// config word of one slave
	function automatic logic [DW-1:0] cfg_word(input bmx_kind_t k,
			input logic [MIW-1:0] p);
		logic [DW-1:0] w;
		w = '0;
		w[SCFG_KIND_LSB +: SCFG_KIND_W] = k;
		w[SCFG_PIN_LSB +: MIW] = p;
		return w;
	endfunction : cfg_word

	assign s_axi_awready = !awHeld;
	assign s_axi_wready = !wHeld;
	assign s_axi_arready = !s_axi_rvalid;

	// register bus next values: write after both halves held, read at once
	always_comb begin
		next_remap = remap;
		next_kindCfg = kindCfg;
		next_pinnedCfg = pinnedCfg;
		next_awHeld = awHeld;
		next_awAddr = awAddr;
		next_wHeld = wHeld;
		next_wData = wData;
		next_wStrb = wStrb;
		next_bresp = s_axi_bresp;
		next_bvalid = s_axi_bvalid;
		next_rdata = s_axi_rdata;
		next_rresp = s_axi_rresp;
		next_rvalid = s_axi_rvalid;
		wrSlot = reg_slot(awAddr, SCFG_BASE);
		rdCfg = reg_slot(s_axi_araddr, SCFG_BASE);
		rdStat = reg_slot(s_axi_araddr, STAT_BASE);
		word = '0;
		if (s_axi_bvalid && s_axi_bready) begin
			next_bvalid = 1'h0;
		end
		if (awHeld && wHeld && !s_axi_bvalid) begin
			next_awHeld = 1'h0;
			next_wHeld = 1'h0;
			next_bvalid = 1'h1;
			next_bresp = RESP_SLVERR;
			if (awAddr == REMAP_OFS) begin
				word = merge_strobe(DW'(remap), wData, wStrb);
				next_remap = word[NM-1:0];
				next_bresp = RESP_OKAY;
			end else if (wrSlot[MIW]) begin
				word = merge_strobe(cfg_word(kindCfg[wrSlot[MIW-1:0]],
					pinnedCfg[wrSlot[MIW-1:0]]), wData, wStrb);
				next_kindCfg[wrSlot[MIW-1:0]] =
					bmx_kind_t'(word[SCFG_KIND_LSB +: SCFG_KIND_W]);
				next_pinnedCfg[wrSlot[MIW-1:0]] = word[SCFG_PIN_LSB +: MIW];
				next_bresp = RESP_OKAY;
			end
		end
		if (s_axi_awvalid && !awHeld) begin
			next_awHeld = 1'h1;
			next_awAddr = s_axi_awaddr;
		end
		if (s_axi_wvalid && !wHeld) begin
			next_wHeld = 1'h1;
			next_wData = s_axi_wdata;
			next_wStrb = s_axi_wstrb;
		end
		if (s_axi_rvalid && s_axi_rready) begin
			next_rvalid = 1'h0;
		end
		if (s_axi_arvalid && !s_axi_rvalid) begin
			next_rvalid = 1'h1;
			next_rresp = RESP_OKAY;
			next_rdata = '0;
			if (s_axi_araddr == REMAP_OFS) begin
				next_rdata = DW'(remap);
			end else if (rdCfg[MIW]) begin
				next_rdata = cfg_word(kindCfg[rdCfg[MIW-1:0]],
					pinnedCfg[rdCfg[MIW-1:0]]);
			end else if (rdStat[MIW]) begin
				next_rdata[STAT_VALID_BIT] = ownerValid[rdStat[MIW-1:0]];
				next_rdata[STAT_OWNER_LSB +: MIW] = owner[rdStat[MIW-1:0]];
			end else begin
				next_rresp = RESP_SLVERR;
			end
		end
	end

	// register bus registers
	always_ff @(posedge clk_sys or negedge rst_n) begin
		if (!rst_n) begin
			remap <= REMAP_RST;
			for (int s = 0; s < NS; s++) begin
				kindCfg[s] <= KIND_RST;
				pinnedCfg[s] <= PIN_RST;
			end
			awHeld <= 1'h0;
			awAddr <= '0;
			wHeld <= 1'h0;
			wData <= '0;
			wStrb <= '0;
			s_axi_bresp <= RESP_OKAY;
			s_axi_bvalid <= 1'h0;
			s_axi_rdata <= '0;
			s_axi_rresp <= RESP_OKAY;
			s_axi_rvalid <= 1'h0;
		end else begin
			remap <= next_remap;
			kindCfg <= next_kindCfg;
			pinnedCfg <= next_pinnedCfg;
			awHeld <= next_awHeld;
			awAddr <= next_awAddr;
			wHeld <= next_wHeld;
			wData <= next_wData;
			wStrb <= next_wStrb;
			s_axi_bresp <= next_bresp;
			s_axi_bvalid <= next_bvalid;
			s_axi_rdata <= next_rdata;
			s_axi_rresp <= next_rresp;
			s_axi_rvalid <= next_rvalid;
		end
	end

	// per master address decode
	always_comb begin
		for (int m = 0; m < NM; m++) begin
			{mHit[m], mTarget[m]} = decode_target(MIW'(m), mAddr[m], remap[m]);
		end
	end

	// request vectors and slave side routing
	always_comb begin
		for (int s = 0; s < NS; s++) begin
			for (int m = 0; m < NM; m++) begin
				reqVec[s][m] = mReq[m] && mHit[m] && (mTarget[m] == MIW'(s))
					&& PERMIT[s][m];
			end
			sSel[s] = ownerValid[s] && reqVec[s][owner[s]];
			sAddr[s] = mAddr[owner[s]];
			sWrite[s] = mWrite[owner[s]];
			sWdata[s] = mWdata[owner[s]];
			sLast[s] = mLast[owner[s]];
			sMaster[s] = owner[s];
			beatDone[s] = sSel[s] && sReady[s];
			beatLast[s] = mLast[owner[s]];
		end
	end

	// master side answers; unmapped or unwired requests get the error answer
	always_comb begin
		for (int m = 0; m < NM; m++) begin
			mReady[m] = errPend[m] || (mHit[m] && sSel[mTarget[m]]
				&& (owner[mTarget[m]] == MIW'(m)) && sReady[mTarget[m]]);
			mErr[m] = errPend[m];
			mRdata[m] = sRdata[mTarget[m]];
			next_errPend[m] = mReq[m] && !mHit[m] && !errPend[m];
		end
	end

	// error answer for unmapped or unwired addresses
	always_ff @(posedge clk_sys or negedge rst_n) begin
		if (!rst_n) begin
			errPend <= '0;
		end else begin
			errPend <= next_errPend;
		end
	end

	for (genvar s = 0; s < NS; s++) begin : gArb
		bmx_slave_arbiter #(
			.ALLOW(PERMIT[s])
		) uArb (
			.clk_sys(clk_sys),
			.rst_n(rst_n),
			.reqVec(reqVec[s]),
			.beatDone(beatDone[s]),
			.beatLast(beatLast[s]),
			.kind(kindCfg[s]),
			.pinned(pinnedCfg[s]),
			.owner(owner[s]),
			.ownerValid(ownerValid[s])
		);
	end

endmodule : bmx_matrix
`default_nettype wire

// ===== design/bmx_pkg.sv
// bmx_pkg: constants, types and shared functions of the bus matrix.
// Assumes one system clock domain and AXI4-Lite register access.
package bmx_pkg;

	localparam int NM = 12;        // master ports
	localparam int NS = 10;        // slave ports
	localparam int MIW = 4;        // master / slave index width
	localparam int AW = 32;        // system address width
	localparam int DW = 32;        // system data width
	localparam int RAW = 12;       // register address width
	localparam int STRB_W = 4;
	localparam int BYTE_W = 8;
	localparam int WORD_BYTES = 4;

	// default master kind, value 3 behaves as no default
	typedef enum logic [1:0] {
		KIND_NONE = 2'b00,
		KIND_LAST = 2'b01,
		KIND_FIXED = 2'b10,
		KIND_SPARE = 2'b11
	} bmx_kind_t;

	// slave port numbers
	localparam logic [MIW-1:0] SLV_SRAM = 4'h0;
	localparam logic [MIW-1:0] SLV_ROM = 4'h1;
	localparam logic [MIW-1:0] SLV_MODEM = 4'h2;
	localparam logic [MIW-1:0] SLV_USB = 4'h3;
	localparam logic [MIW-1:0] SLV_EBI = 4'h4;
	localparam logic [MIW-1:0] SLV_MEM1 = 4'h5;
	localparam logic [MIW-1:0] SLV_MEM2 = 4'h6;
	localparam logic [MIW-1:0] SLV_MEM3 = 4'h7;
	localparam logic [MIW-1:0] SLV_BRG0 = 4'h8;
	localparam logic [MIW-1:0] SLV_BRG1 = 4'h9;

	// masters wired to each slave, bit m for master m
	localparam logic [NM-1:0] PERMIT [NS] = '{
		12'hFFF, 12'h03F, 12'h033, 12'h003, 12'hFFF,
		12'h00D, 12'h032, 12'h200, 12'h03F, 12'h03F};

	// address map
	localparam int REGION_MSB = 31;
	localparam int REGION_W = 4;
	localparam int SUB_MSB = 27;
	localparam int SUB_W = 8;
	localparam int BRG_SEL_BIT = 27;
	localparam logic [3:0] REGION_INT = 4'h0;
	localparam logic [3:0] REGION_EBI = 4'h1;
	localparam logic [3:0] REGION_MEM = 4'h2;
	localparam logic [3:0] REGION_BRG = 4'hF;
	localparam logic [7:0] SUB_BOOT = 8'h00;
	localparam logic [7:0] SUB_ROM = 8'h01;
	localparam logic [7:0] SUB_SRAM = 8'h03;
	localparam logic [7:0] SUB_MODEM = 8'h05;
	localparam logic [7:0] SUB_USB = 8'h06;

	// register map
	localparam logic [RAW-1:0] REMAP_OFS = 12'h000;
	localparam logic [RAW-1:0] SCFG_BASE = 12'h040;
	localparam logic [RAW-1:0] STAT_BASE = 12'h080;
	localparam int SCFG_KIND_LSB = 0;
	localparam int SCFG_KIND_W = 2;
	localparam int SCFG_PIN_LSB = 4;
	localparam int STAT_VALID_BIT = 0;
	localparam int STAT_OWNER_LSB = 4;
	localparam logic [NM-1:0] REMAP_RST = 12'h000;
	localparam bmx_kind_t KIND_RST = KIND_LAST;
	localparam logic [MIW-1:0] PIN_RST = 4'h0;
	localparam logic [1:0] RESP_OKAY = 2'h0;
	localparam logic [1:0] RESP_SLVERR = 2'h2;

	// round robin: first requester after the last owner, owner itself last
	function automatic logic [MIW-1:0] rr_pick(input logic [NM-1:0] vec,
			input logic [MIW-1:0] last);
		logic [MIW-1:0] pick;
		int j;
		pick = last;
		for (int i = NM; i >= 1; i--) begin
			j = (int'(last) + i) % NM;
			if (vec[j]) begin
				pick = MIW'(j);
			end
		end
		return pick;
	endfunction : rr_pick

	// per master decode, result is {hit, slave}
	function automatic logic [MIW:0] decode_target(input logic [MIW-1:0] m,
			input logic [AW-1:0] a, input logic remap);
		logic [MIW-1:0] s;
		logic hit;
		s = SLV_SRAM;
		hit = 1'h1;
		case (a[REGION_MSB -: REGION_W])
			REGION_INT: begin
				case (a[SUB_MSB -: SUB_W])
					SUB_BOOT: s = remap ? SLV_SRAM : SLV_ROM;
					SUB_ROM: s = SLV_ROM;
					SUB_SRAM: s = SLV_SRAM;
					SUB_MODEM: s = SLV_MODEM;
					SUB_USB: s = SLV_USB;
					default: hit = 1'h0;
				endcase
			end
			REGION_EBI: s = SLV_EBI;
			REGION_MEM: begin
				if (PERMIT[SLV_MEM1][m]) begin
					s = SLV_MEM1;
				end else if (PERMIT[SLV_MEM2][m]) begin
					s = SLV_MEM2;
				end else begin
					s = SLV_MEM3;
				end
			end
			REGION_BRG: s = a[BRG_SEL_BIT] ? SLV_BRG1 : SLV_BRG0;
			default: hit = 1'h0;
		endcase
		hit = hit && PERMIT[s][m];
		return {hit, s};
	endfunction : decode_target

	// register slot within a block of NS words, result is {hit, index}
	function automatic logic [MIW:0] reg_slot(input logic [RAW-1:0] addr,
			input logic [RAW-1:0] base);
		logic [RAW-1:0] d;
		logic hit;
		d = addr - base;
		hit = (addr >= base) && (d < RAW'(NS * WORD_BYTES)) && (d[1:0] == 2'h0);
		return {hit, d[MIW+1:2]};
	endfunction : reg_slot

	// byte lane merge of a write
	function automatic logic [DW-1:0] merge_strobe(input logic [DW-1:0] old,
			input logic [DW-1:0] wr, input logic [STRB_W-1:0] strb);
		logic [DW-1:0] res;
		res = old;
		for (int b = 0; b < STRB_W; b++) begin
			if (strb[b]) begin
				res[b*BYTE_W +: BYTE_W] = wr[b*BYTE_W +: BYTE_W];
			end
		end
		return res;
	endfunction : merge_strobe

endpackage : bmx_pkg

// ===== design/bmx_slave_arbiter.sv
// bmx_slave_arbiter: owner selection and default master for one slave.
// Assumes requests already masked to wired masters of this slave.
`timescale 1ns/1ps
`default_nettype none
module bmx_slave_arbiter
	import bmx_pkg::*;
#(
	parameter logic [NM-1:0] ALLOW = 12'hFFF
) (
	input wire logic clk_sys,
	input wire logic rst_n,
	input wire logic [NM-1:0] reqVec,
	input wire logic beatDone,
	input wire logic beatLast,
	input wire bmx_kind_t kind,
	input wire logic [MIW-1:0] pinned,
	output logic [MIW-1:0] owner,
	output logic ownerValid
);

	logic burstOpen;
	logic [MIW-1:0] next_owner;
	logic next_ownerValid;
	logic next_burstOpen;
	logic locked;

	// next owner: hold inside a burst, else arbitrate, else default
	always_comb begin
		next_owner = owner;
		next_ownerValid = ownerValid;
		next_burstOpen = burstOpen;
		if (beatDone) begin
			next_burstOpen = !beatLast;
		end
		locked = ownerValid && (burstOpen || reqVec[owner])
			&& !(beatDone && beatLast);
		if (!locked) begin
			next_burstOpen = 1'h0;
			if (|reqVec) begin
				next_owner = rr_pick(reqVec, owner);
				next_ownerValid = 1'h1;
			end else begin
				case (kind)
					KIND_LAST: begin
						next_ownerValid = ownerValid;
					end
					KIND_FIXED: begin
						// connect pinned master
						// an out-of-range or unwired pin leaves owner index as is
						next_ownerValid = (pinned < MIW'(NM)) && ALLOW[pinned];
						next_owner = next_ownerValid ? pinned : owner;
					end
					default: begin
						next_ownerValid = 1'h0;
					end
				endcase
			end
		end
	end

	// owner registers
	always_ff @(posedge clk_sys or negedge rst_n) begin
		if (!rst_n) begin
			owner <= 4'h0;
			ownerValid <= 1'h0;
			burstOpen <= 1'h0;
		end else begin
			owner <= next_owner;
			ownerValid <= next_ownerValid;
			burstOpen <= next_burstOpen;
		end
	end

endmodule : bmx_slave_arbiter
`default_nettype wire

// ===== tb/bmx_matrix_sva.sv
// bmx_matrix_sva: port checks of the bus matrix.
// Assumes it is bound into bmx_matrix, one clock domain.
`timescale 1ns/1ps
`default_nettype none
module bmx_matrix_sva
	import bmx_pkg::*;
(
	input wire logic clk_sys,
	input wire logic rst_n,
	input wire logic [NM-1:0] mReq,
	input wire logic [NM-1:0] mReady,
	input wire logic [NM-1:0] mErr,
	input wire logic [NS-1:0] sSel,
	input wire logic [NS-1:0] sLast,
	input wire logic [MIW-1:0] sMaster [NS],
	input wire logic [NS-1:0] sReady,
	input wire logic s_axi_arvalid,
	input wire logic s_axi_arready,
	input wire logic s_axi_rvalid,
	input wire logic s_axi_rready
);
	logic [NM-1:0] served;
	default clocking cb @(posedge clk_sys);
	endclocking
	default disable iff (!rst_n);
	// masters whose beat some slave finishes this cycle
	always_comb begin
		served = '0;
		for (int s = 0; s < NS; s++) begin
			if (sSel[s] && sReady[s]) begin
				served[sMaster[s]] = 1'b1;
			end
		end
	end
	// error only as answer to a request
	chk_err_ready: assert property (
		(mErr & ~(mReady & $past(mReq))) == '0)
		else $error("error flag without ready or request");
	chk_err_pulse: assert property (mErr != '0 |=> (mErr & $past(mErr)) == '0)
		else $error("error flag held too long");
	chk_ready_cause: assert property ((mReady & ~mErr) == served)
		else $error("ready does not match slave beats");
	chk_read_resp: assert property (
		s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
		else $error("read answer late");
	chk_read_stand: assert property (
		s_axi_rvalid |=> s_axi_rvalid == !$past(s_axi_rready))
		else $error("read answer dropped early or held too long");
	for (genvar s = 0; s < NS; s++) begin : g_slv
		chk_wired_path: assert property (sSel[s] |-> PERMIT[s][sMaster[s]])
			else $error("unwired master reached a slave");
		chk_sel_req: assert property (sSel[s] |-> mReq[sMaster[s]])
			else $error("slave selected without request");
		chk_burst_hold: assert property (
			sSel[s] && !(sReady[s] && sLast[s])
			|=> sMaster[s] == $past(sMaster[s]))
			else $error("owner changed inside a burst");
	end
endmodule : bmx_matrix_sva
bind bmx_matrix bmx_matrix_sva bmx_matrix_sva_i (.clk_sys(clk_sys),
	.rst_n(rst_n), .mReq(mReq), .mReady(mReady), .mErr(mErr), .sSel(sSel),
	.sLast(sLast), .sMaster(sMaster), .sReady(sReady),
	.s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready),
	.s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready));
`default_nettype wire

// ===== tb/bmx_slave_model.sv
// bmx_slave_model: ten slaves answering the matrix, optionally slow.
// Assumes sSel and sAddr come straight from the matrix ports.
`timescale 1ns/1ps
`default_nettype none
module bmx_slave_model
	import bmx_pkg::*;
(
	input wire logic clk_sys,
	input wire logic rst_n,
	input wire logic slow,
	input wire logic [NS-1:0] sSel,
	input wire logic [AW-1:0] sAddr [NS],
	output logic [NS-1:0] sReady,
	output logic [DW-1:0] sRdata [NS]
);
	logic phase, next_phase;
	logic [DW-1:0] noise, next_noise;
	// wait-state phase and a pattern that changes every cycle
	always_comb begin
		next_phase = !phase;
		next_noise = ~noise + 32'h1;
	end
	always_ff @(posedge clk_sys or negedge rst_n) begin
		if (!rst_n) begin
			phase <= 1'b0;
			noise <= 32'hA5A5_5A5A;
		end else begin
			phase <= next_phase;
			noise <= next_noise;
		end
	end
	// selected slaves answer with address and index, others show garbage
	always_comb begin
		for (int s = 0; s < NS; s++) begin
			sReady[s] = sSel[s] && (!slow || phase);
			sRdata[s] = sSel[s] ? (sAddr[s] | DW'(s)) : noise;
		end
	end
endmodule : bmx_slave_model
`default_nettype wire

// ===== tb/bmx_matrix_bench.sv
// bmx_matrix_bench: register and master-port tests of the bus matrix.
// Assumes bmx_slave_model answers every slave port.
`timescale 1ns/1ps
`default_nettype none
module bmx_matrix_bench
	import bmx_pkg::*;
;
	logic clk_sys, rst_n = 0, slow = 0, awValid = 0, wValid = 0, bReady = 0;
	logic arValid = 0, rReady = 0, awReady, wReady, bValid, arReady, rValid;
	logic [RAW-1:0] awAddr = 0, arAddr = 0;
	logic [DW-1:0] wData = 0, rData;
	logic [STRB_W-1:0] wStrb = 0;
	logic [1:0] bResp, rResp;
	logic [NM-1:0] mReq = 0, mWrite = 0, mLast = 0, mReady, mErr;
	logic [AW-1:0] mAddr [NM] = '{default: '0};
	logic [DW-1:0] mWdata [NM] = '{default: '0};
	logic [DW-1:0] mRdata [NM];
	logic [NS-1:0] sSel, sReady, sWrite, sLast;
	logic [AW-1:0] sAddr [NS];
	logic [DW-1:0] sRdata [NS], sWdata [NS];
	logic [MIW-1:0] sMaster [NS];
	int num_errors = 0, compares = 0, la, lb, lc;
	localparam logic [NM-1:0] OK [NS] = '{12'hFFF, 12'h03F, 12'h033,
		12'h003, 12'hFFF, 12'h00D, 12'h032, 12'h200, 12'h03F, 12'h03F};
	localparam logic [AW-1:0] TGT [8] = '{32'h0030_0000, 32'h0010_0000,
		32'h0050_0000, 32'h0060_0000, 32'h1000_0000, 32'hF000_0000,
		32'hF800_0000, 32'h2000_0000};
	localparam int SX [8] = '{0, 1, 2, 3, 4, 8, 9, 5};
	localparam logic [RAW-1:0] CFG4 = SCFG_BASE + 12'h010;
	localparam logic [RAW-1:0] STAT4 = STAT_BASE + 12'h010;
	localparam logic [DW-1:0] ALL = 32'hFFFF_FFFF;

	bmx_matrix bmx_matrix_i (.clk_sys(clk_sys), .rst_n(rst_n),
		.s_axi_awaddr(awAddr), .s_axi_awvalid(awValid), .s_axi_awready(awReady),
		.s_axi_wdata(wData), .s_axi_wstrb(wStrb), .s_axi_wvalid(wValid),
		.s_axi_wready(wReady), .s_axi_bresp(bResp), .s_axi_bvalid(bValid),
		.s_axi_bready(bReady), .s_axi_araddr(arAddr), .s_axi_arvalid(arValid),
		.s_axi_arready(arReady), .s_axi_rdata(rData), .s_axi_rresp(rResp),
		.s_axi_rvalid(rValid), .s_axi_rready(rReady), .mReq(mReq),
		.mAddr(mAddr), .mWrite(mWrite), .mWdata(mWdata), .mLast(mLast),
		.mReady(mReady), .mErr(mErr), .mRdata(mRdata), .sSel(sSel),
		.sAddr(sAddr), .sWrite(sWrite), .sWdata(sWdata), .sLast(sLast),
		.sMaster(sMaster),
		.sReady(sReady), .sRdata(sRdata));
	bmx_slave_model bmx_slave_model_i (.clk_sys(clk_sys), .rst_n(rst_n),
		.slow(slow), .sSel(sSel), .sAddr(sAddr), .sReady(sReady),
		.sRdata(sRdata));

	// clock generation
	initial begin
		clk_sys = 1'b0;
		forever #5 clk_sys = ~clk_sys;
	end

	task automatic check(input logic [DW-1:0] got, input logic [DW-1:0] exp);
		compares++;
		if (got !== exp) begin
			num_errors++;
			$display("unexpected at %0t: %h vs %h", $time, got, exp);
		end
	endtask : check

	task automatic give_verdict();
		$display("compares %0d num_errors %0d", compares, num_errors);
		if (num_errors == 0 && compares > 0)
			$display("All checks passed");
		else
			$display("Checks failed");
		$finish;
	endtask : give_verdict

	// one master beat; s = NS expects an error answer
	task automatic beat(input int m, input logic [AW-1:0] a, input logic lst,
			input int s, output int lat);
		logic rdy, er, wr, ls;
		logic [DW-1:0] rd, wd;
		logic [MIW-1:0] own;
		lat = 0;
		rdy = 1'b0;
		@(posedge clk_sys);
		mReq[m] <= 1'b1;
		mAddr[m] <= a;
		mLast[m] <= lst;
		mWrite[m] <= lst;
		mWdata[m] <= ~a;
		while (!rdy) begin
			@(negedge clk_sys);
			rdy = mReady[m];
			er = mErr[m];
			rd = mRdata[m];
			own = sMaster[s % NS];
			wr = sWrite[s % NS];
			ls = sLast[s % NS];
			wd = sWdata[s % NS];
			if (!rdy) lat++;
			@(posedge clk_sys);
		end
		mReq[m] <= 1'b0;
		check(DW'(er), DW'(s >= NS));
		if (s < NS) begin
			check(rd, a | DW'(s));
			check(DW'(own), DW'(m));
			check(DW'({wr, ls}), DW'({lst, lst}));
			check(wd, ~a);
		end
	endtask : beat

	task automatic ebi(input int m, input int el);
		int lat;
		beat(m, TGT[4], 1'b1, 4, lat);
		check(DW'(lat), DW'(el));
	endtask : ebi

	task automatic axi_wr(input logic [RAW-1:0] a, input logic [DW-1:0] d,
			input logic [STRB_W-1:0] st, input logic [1:0] er);
		logic aw, w, b;
		b = 1'b0;
		@(posedge clk_sys);
		awAddr <= a;
		awValid <= 1'b1;
		wData <= d;
		wStrb <= st;
		wValid <= 1'b1;
		bReady <= 1'b1;
		while (!b) begin
			@(negedge clk_sys);
			aw = awValid && awReady;
			w = wValid && wReady;
			b = bValid;
			if (b) check(DW'(bResp), DW'(er));
			@(posedge clk_sys);
			if (aw) awValid <= 1'b0;
			if (w) wValid <= 1'b0;
		end
		bReady <= 1'b0;
	endtask : axi_wr

	task automatic axi_rd(input logic [RAW-1:0] a, input logic [DW-1:0] msk,
			input logic [DW-1:0] ex, input logic [1:0] er);
		logic r, ar;
		logic [1:0] rs;
		r = 1'b0;
		@(posedge clk_sys);
		arAddr <= a;
		arValid <= 1'b1;
		rReady <= 1'b1;
		while (!r) begin
			@(negedge clk_sys);
			ar = arValid && arReady;
			r = rValid;
			rs = rResp;
			if (r) check(rData & msk, ex);
			@(posedge clk_sys);
			// address released only after the edge that took it
			if (ar) arValid <= 1'b0;
		end
		rReady <= 1'b0;
		check(DW'(rs), DW'(er));
	endtask : axi_rd

	// watchdog against a hang
	initial begin
		repeat (20000) @(posedge clk_sys);
		num_errors++;
		give_verdict();
	end

	// main sequence
	initial begin
		int s, lat;
		repeat (16) @(posedge clk_sys);
		rst_n <= 1'b1;
		axi_rd(SCFG_BASE + 12'h024, ALL, 32'h1, RESP_OKAY);
		axi_rd(REMAP_OFS, ALL, 32'h0, RESP_OKAY);
		axi_rd(12'hFFC, ALL, 32'h0, RESP_SLVERR);
		axi_wr(STAT_BASE, 32'h1, 4'hF, RESP_SLVERR);
		// every master against every target, slaves stalling
		slow <= 1'b1;
		for (int m = 0; m < NM; m++) begin
			for (int t = 0; t < 8; t++) begin
				s = SX[t];
				if (t == 7 && (m == 1 || m == 4 || m == 5)) s = 6;
				if (t == 7 && m > 5) s = 7;
				if (!OK[s][m]) s = NS;
				beat(m, TGT[t], 1'b1, s, lat);
			end
		end
		slow <= 1'b0;
		beat(6, 32'h0, 1'b1, NS, lat);
		axi_wr(REMAP_OFS, 32'h42, 4'hF, RESP_OKAY);
		axi_rd(REMAP_OFS, ALL, 32'h42, RESP_OKAY);
		beat(6, 32'h0, 1'b1, 0, lat);
		beat(1, 32'h0, 1'b1, 0, lat);
		beat(0, 32'h0, 1'b1, 1, lat);
		// last access kind, pinned index ignored
		axi_wr(CFG4, 32'h51, 4'hF, RESP_OKAY);
		ebi(2, 1);
		ebi(2, 0);
		ebi(7, 1);
		ebi(7, 0);
		axi_rd(STAT4, 32'hFF, 32'h71, RESP_OKAY);
		// no default master, spare code too
		axi_wr(CFG4, 32'h3, 4'hF, RESP_OKAY);
		axi_rd(STAT4, 32'h1, 32'h0, RESP_OKAY);
		ebi(7, 1);
		axi_wr(CFG4, 32'h0, 4'hF, RESP_OKAY);
		ebi(7, 1);
		ebi(7, 1);
		axi_rd(STAT4, 32'h1, 32'h0, RESP_OKAY);
		// fixed kind written through one byte lane
		axi_wr(CFG4, 32'hFFFF_FF52, 4'h1, RESP_OKAY);
		axi_rd(CFG4, ALL, 32'h52, RESP_OKAY);
		axi_rd(STAT4, 32'hFF, 32'h51, RESP_OKAY);
		ebi(5, 0);
		ebi(7, 1);
		ebi(5, 0);
		// contention with a two-beat burst on the SRAM
		beat(7, TGT[0], 1'b1, 0, lat);
		fork
			begin
				beat(2, TGT[0], 1'b0, 0, la);
				beat(2, TGT[0], 1'b1, 0, lb);
			end
			beat(3, TGT[0], 1'b1, 0, lc);
		join
		check(DW'(la), 32'h1);
		check(DW'(lb), 32'h0);
		check(DW'(lc), 32'h4);
		give_verdict();
	end
endmodule : bmx_matrix_bench
`default_nettype wire
